// ### logic/thd_alarm_timer_event_log.sv
// harmonic distortion alarm timing, event stream and record log
//
// Functional notes
// - the phase alarm fires after a definite delay, 0 to 1800 s in 5 ms steps, default 10 s.
// - the first residual input has its own delay with the same range, step and default.
// - the second residual input has its own delay with the same range, step and default.
// - every change of start and alarm for each channel, and of the common blocked, raises an event.
// - a mask bit per event decides whether it enters the main event buffer.
// - each event is emitted with a time stamp taken in the cycle it is granted from the pending set.
// - cumulative counters count start, alarm and blocked occurrences and clear on command.
// - only the latest twelve records are kept, the oldest one being overwritten.
// - a record is captured only for rising start, alarm and blocked conditions.
// - a record holds time in ms, event identity and the distortion of each phase.
// - a record also holds the active setting group.
// - start, alarm and blocked are plain outputs for contacts and user logic.
// - pick-up asserts above the setting and releases below 97 percent of it, or when its channel is disabled.
// - pick-up while blocking is active gives blocked instead of start and stops timing.
// - one common setting selects amplitude or power ratio for all channels.
`timescale 1ns/1ps
`default_nettype none
`include "thd_alarm_map.svh"
module thd_alarm_timer_event_log #(
  parameter int TICK_CYCLES = `THD_STEP_NS / `THD_CLK_NS,
  parameter int REC_DEPTH   = `THD_REC_DEPTH,
  parameter int THD_W       = 16
) (
  input  wire logic               i_clock,      // 250 MHz core clock
  input  wire logic               i_nrst,       // sync reset, active low
  input  wire logic               i_psel,       // apb select
  input  wire logic               i_penable,    // apb enable
  input  wire logic               i_pwrite,     // apb direction
  input  wire logic [7:0]         i_paddr,      // apb byte address
  input  wire logic [31:0]        i_pwdata,     // apb write data
  output logic      [31:0]        o_prdata,     // apb read data
  output logic                    o_pready,     // apb ready
  output logic                    o_pslverr,    // apb error, unmapped
  input  wire logic [5*THD_W-1:0] i_thd_amp,    // amplitude ratio L1,L2,L3,R1,R2
  input  wire logic [5*THD_W-1:0] i_thd_pow,    // power ratio L1,L2,L3,R1,R2
  input  wire logic               i_block,      // blocking input
  input  wire logic [2:0]         i_set_group,  // active setting group
  input  wire logic [47:0]        i_timestamp,  // time in ms
  output logic      [2:0]         o_start,      // start per channel
  output logic      [2:0]         o_alarm,      // alarm per channel
  output logic                    o_blocked,    // blocked, any channel
  output logic                    o_evt_valid,  // event pulse
  output logic      [3:0]         o_evt_code,   // event identity
  output logic      [47:0]        o_evt_time    // event time stamp
);
  localparam int RW = 48 + 3 + 4 + 3 * THD_W;
  localparam int FULL_PCT = `THD_FULL_PCT;
  localparam int RST_PCT  = `THD_RST_PCT;

  thd_alarm_pkg::chan_state_e st_reg [3];
  thd_alarm_pkg::chan_state_e st_next [3];
  thd_alarm_pkg::pick_t pick_reg [3];
  thd_alarm_pkg::dly_t  dly_reg [3];
  thd_alarm_pkg::dly_t  tmr_reg [3];
  thd_alarm_pkg::cnt_t  cnt_st_reg, cnt_al_reg, cnt_bl_reg;
  logic [3:0]   ctrl_reg;
  logic [13:0]  mask_reg, pend_reg, pend_next, edges, grant;
  logic [3:0]   sel_reg, gcode, ptr_reg, fill_reg, rcode;
  logic [6:0]   prev_reg, cond, rise, fall, rpend_reg, rpend_next, rgrant;
  logic [2:0]   pu_reg, rel, over, blk_ch;
  logic [20:0]  div_reg;
  logic [THD_W-1:0] thd_sel [5];
  logic [THD_W-1:0] chan_thd [3];
  logic [RW-1:0]    rec_rdata;
  logic [31:0]      rdata_next;
  logic             hit;

  // apb decode, zero wait states
  wire setup    = i_psel & ~i_penable;
  wire wr_en    = i_psel & i_penable & i_pwrite;
  wire wr_ctrl  = wr_en & (i_paddr == `THD_OFS_CTRL);
  wire wr_mask  = wr_en & (i_paddr == `THD_OFS_EVT_MASK);
  wire wr_sel   = wr_en & (i_paddr == `THD_OFS_REC_SEL);
  wire cnt_clr  = wr_ctrl & i_pwdata[`THD_CTRL_CLR];
  wire mode_pow = ctrl_reg[`THD_CTRL_MODE];
  wire [2:0] en = ctrl_reg[`THD_CTRL_EN_LSB +: 3];
  wire tick     = (div_reg == 21'(TICK_CYCLES - 1));
  wire rec_we   = |rpend_reg;
  wire [3:0] raddr = wr_sel ? i_pwdata[3:0] : sel_reg;
  assign o_pready = 1'b1;

  // control, mask and record select registers
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ctrl_reg <= {`THD_EN_RST, 1'b0};
      mask_reg <= `THD_MASK_RST;
      sel_reg  <= 4'h0;
    end else begin
      if (wr_ctrl) ctrl_reg <= i_pwdata[3:0];
      if (wr_mask) mask_reg <= i_pwdata[13:0];
      if (wr_sel)  sel_reg  <= i_pwdata[3:0];
    end
  end

  // program-cycle tick, one per delay step
  always_ff @(posedge i_clock) begin
    if (!i_nrst) div_reg <= 21'h0;
    else div_reg <= tick ? 21'h0 : div_reg + 21'h1;
  end

  genvar k;
  for (k = 0; k < 5; k++) begin : g_sel
    assign thd_sel[k] = mode_pow ? i_thd_pow[k*THD_W +: THD_W] : i_thd_amp[k*THD_W +: THD_W];
  end

  // phase group follows the worst phase
  wire [THD_W-1:0] m01 = (thd_sel[0] > thd_sel[1]) ? thd_sel[0] : thd_sel[1];
  assign chan_thd[0] = (m01 > thd_sel[2]) ? m01 : thd_sel[2];
  assign chan_thd[1] = thd_sel[3];
  assign chan_thd[2] = thd_sel[4];

  genvar c;
  for (c = 0; c < 3; c++) begin : g_ch
    wire [23:0] lhs = 24'(chan_thd[c]) * 24'(FULL_PCT);
    wire [23:0] rhs = 24'(pick_reg[c]) * 24'(RST_PCT);
    wire wr_pick = wr_en & (i_paddr == `THD_OFS_PICK_PH + 8'(c) * `THD_WORD);
    wire wr_dly  = wr_en & (i_paddr == `THD_OFS_DLY_PH + 8'(c) * `THD_WORD);
    wire due = (dly_reg[c] == 19'h0) | (tmr_reg[c] > dly_reg[c]);
    assign over[c] = chan_thd[c] > THD_W'(pick_reg[c]);
    assign rel[c] = lhs < rhs;

    // per-channel settings
    always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
        pick_reg[c] <= `THD_PICK_RST;
        dly_reg[c]  <= `THD_DLY_RST;
      end else begin
        if (wr_pick) pick_reg[c] <= i_pwdata[13:0];
        if (wr_dly)  dly_reg[c]  <= i_pwdata[18:0];
      end
    end

    always_ff @(posedge i_clock) begin
      if (!i_nrst || !en[c]) pu_reg[c] <= 1'b0;
      else if (over[c]) pu_reg[c] <= 1'b1;
      else if (rel[c]) pu_reg[c] <= 1'b0;
    end

    always_comb begin
      st_next[c] = st_reg[c];
      unique case (st_reg[c])
        thd_alarm_pkg::ST_NORMAL:
          if (pu_reg[c]) st_next[c] = i_block ? thd_alarm_pkg::ST_BLOCKED : thd_alarm_pkg::ST_START;
        thd_alarm_pkg::ST_START:
          if (!pu_reg[c]) st_next[c] = thd_alarm_pkg::ST_NORMAL;
          else if (i_block) st_next[c] = thd_alarm_pkg::ST_BLOCKED;
          else if (due) st_next[c] = thd_alarm_pkg::ST_ALARM;
        thd_alarm_pkg::ST_ALARM, thd_alarm_pkg::ST_BLOCKED:
          if (!pu_reg[c]) st_next[c] = thd_alarm_pkg::ST_NORMAL;
      endcase
    end

    always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
        st_reg[c]  <= thd_alarm_pkg::ST_NORMAL;
        tmr_reg[c] <= 19'h0;
        o_start[c] <= 1'b0;
        o_alarm[c] <= 1'b0;
        blk_ch[c]  <= 1'b0;
      end else begin
        st_reg[c]  <= st_next[c];
        o_start[c] <= (st_next[c] == thd_alarm_pkg::ST_START) | (st_next[c] == thd_alarm_pkg::ST_ALARM);
        o_alarm[c] <= st_next[c] == thd_alarm_pkg::ST_ALARM;
        blk_ch[c]  <= st_next[c] == thd_alarm_pkg::ST_BLOCKED;
        if (st_reg[c] != thd_alarm_pkg::ST_START) tmr_reg[c] <= 19'h0;
        else if (tick && !due) tmr_reg[c] <= tmr_reg[c] + 19'h1;
      end
    end
  end

  // condition edges, on code even and off code odd
  assign o_blocked = |blk_ch;
  assign cond = {o_blocked, o_alarm, o_start};
  assign rise = cond & ~prev_reg;
  assign fall = ~cond & prev_reg;
  for (k = 0; k < 7; k++) begin : g_edge
    assign edges[2*k]   = rise[k];
    assign edges[2*k+1] = fall[k];
  end

  // masked pending events, a new edge wins over the grant
  assign grant     = pend_reg & (~pend_reg + 14'h1);
  assign pend_next = (pend_reg & ~grant) | (edges & mask_reg);
  assign rgrant     = rpend_reg & (~rpend_reg + 7'h1);
  assign rpend_next = (rpend_reg & ~rgrant) | rise;

  // encode granted event and record
  always_comb begin
    gcode = 4'h0;
    rcode = 4'h0;
    for (int i = 0; i < 14; i++) begin
      if (grant[i]) gcode = 4'(i);
    end
    for (int i = 0; i < 7; i++) begin
      if (rgrant[i]) rcode = 4'(2 * i);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      prev_reg    <= 7'h0;
      pend_reg    <= 14'h0;
      rpend_reg   <= 7'h0;
      o_evt_valid <= 1'b0;
      o_evt_code  <= 4'h0;
      o_evt_time  <= 48'h0;
    end else begin
      prev_reg    <= cond;
      pend_reg    <= pend_next;
      rpend_reg   <= rpend_next;
      o_evt_valid <= |pend_reg;
      o_evt_code  <= gcode;
      o_evt_time  <= i_timestamp;
    end
  end

  // cumulative counters, an occurrence wins over clear
  wire [15:0] inc_st = 16'($countones(rise[2:0]));
  wire [15:0] inc_al = 16'($countones(rise[5:3]));
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      cnt_st_reg <= 16'h0;
      cnt_al_reg <= 16'h0;
      cnt_bl_reg <= 16'h0;
    end else begin
      cnt_st_reg <= (cnt_clr ? 16'h0 : cnt_st_reg) + inc_st;
      cnt_al_reg <= (cnt_clr ? 16'h0 : cnt_al_reg) + inc_al;
      cnt_bl_reg <= (cnt_clr ? 16'h0 : cnt_bl_reg) + 16'(rise[6]);
    end
  end

  // ring pointer over the record slots
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ptr_reg  <= 4'h0;
      fill_reg <= 4'h0;
    end else if (rec_we) begin
      ptr_reg <= (ptr_reg == 4'(REC_DEPTH - 1)) ? 4'h0 : ptr_reg + 4'h1;
      if (fill_reg != 4'(REC_DEPTH)) fill_reg <= fill_reg + 4'h1;
    end
  end

  thd_record_mem #(.WIDTH(RW), .DEPTH(REC_DEPTH), .AW(4)) u_rec (
    .i_clock (i_clock),
    .i_we    (rec_we),
    .i_waddr (ptr_reg),
    .i_wdata ({i_timestamp, i_set_group, rcode, thd_sel[2], thd_sel[1], thd_sel[0]}),
    .i_raddr (raddr),
    .o_rdata (rec_rdata)
  );

  // register read selection
  always_comb begin
    hit = 1'b1;
    rdata_next = 32'h0;
    unique case (i_paddr)
      `THD_OFS_CTRL:      rdata_next = {28'h0, ctrl_reg};
      `THD_OFS_PICK_PH:   rdata_next = {18'h0, pick_reg[0]};
      `THD_OFS_PICK_PH + `THD_WORD: rdata_next = {18'h0, pick_reg[1]};
      `THD_OFS_PICK_PH + 8'h08:     rdata_next = {18'h0, pick_reg[2]};
      `THD_OFS_DLY_PH:    rdata_next = {13'h0, dly_reg[0]};
      `THD_OFS_DLY_PH + `THD_WORD:  rdata_next = {13'h0, dly_reg[1]};
      `THD_OFS_DLY_PH + 8'h08:      rdata_next = {13'h0, dly_reg[2]};
      `THD_OFS_EVT_MASK:  rdata_next = {18'h0, mask_reg};
      `THD_OFS_STATUS:    rdata_next = {16'h0, fill_reg, ptr_reg, 1'b0, cond};
      `THD_OFS_CNT_START: rdata_next = {16'h0, cnt_st_reg};
      `THD_OFS_CNT_ALARM: rdata_next = {16'h0, cnt_al_reg};
      `THD_OFS_CNT_BLOCK: rdata_next = {16'h0, cnt_bl_reg};
      `THD_OFS_REC_SEL:   rdata_next = {28'h0, sel_reg};
      `THD_OFS_REC_TS_LO: rdata_next = rec_rdata[RW-1-16 -: 32];
      `THD_OFS_REC_TS_HI: rdata_next = {5'h0, rec_rdata[RW-49 -: 7], rec_rdata[RW-1 -: 16], 4'h0};
      `THD_OFS_REC_THD_A: rdata_next = {rec_rdata[2*THD_W-1 -: 16], rec_rdata[THD_W-1 -: 16]};
      `THD_OFS_REC_THD_B: rdata_next = {16'h0, rec_rdata[3*THD_W-1 -: 16]};
      default:            hit = 1'b0;
    endcase
  end

  // read data and error latched in the setup cycle
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_prdata  <= 32'h0;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_prdata  <= i_pwrite ? 32'h0 : rdata_next;
      o_pslverr <= ~hit;
    end
  end

  // checks on the block's own behaviour
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  property p_ph_delay;
    $rose(o_alarm[0]) |-> $past(o_start[0]) && ($past(dly_reg[0]) == 19'h0 || $past(tmr_reg[0]) > $past(dly_reg[0]));
  endproperty
  a_ph_delay: assert property (p_ph_delay) else $error("phase alarm before delay");
  property p_r1_delay;
    $rose(o_alarm[1]) |-> $past(o_start[1]) && ($past(dly_reg[1]) == 19'h0 || $past(tmr_reg[1]) > $past(dly_reg[1]));
  endproperty
  a_r1_delay: assert property (p_r1_delay) else $error("residual one alarm early");
  property p_r2_delay;
    $rose(o_alarm[2]) |-> $past(o_start[2]) && ($past(dly_reg[2]) == 19'h0 || $past(tmr_reg[2]) > $past(dly_reg[2]));
  endproperty
  a_r2_delay: assert property (p_r2_delay) else $error("residual two alarm early");
  property p_evt_set;
    (rise[0] && mask_reg[0]) |=> pend_reg[0] ##[0:14] o_evt_valid && o_evt_code == 4'h0;
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("start event lost");
  property p_mask;
    (edges[5] && !mask_reg[5] && !pend_reg[5]) |=> !pend_reg[5];
  endproperty
  a_mask: assert property (p_mask) else $error("masked event queued");
  property p_stamp;
    o_evt_valid |-> o_evt_time == $past(i_timestamp) && (($past(pend_reg) & (14'h1 << o_evt_code)) != 14'h0);
  endproperty
  a_stamp: assert property (p_stamp) else $error("event stamp wrong");
  property p_cnt;
    (rise[6] && !cnt_clr) |=> cnt_bl_reg == $past(cnt_bl_reg) + 16'h1;
  endproperty
  a_cnt: assert property (p_cnt) else $error("blocked count missed");
  property p_wrap;
    (rec_we && ptr_reg == 4'(REC_DEPTH - 1)) |=> ptr_reg == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("record pointer no wrap");
  property p_on_only;
    (fall != 7'h0 && rise == 7'h0 && rpend_reg == 7'h0) |=> !rec_we;
  endproperty
  a_on_only: assert property (p_on_only) else $error("record for off edge");
  property p_release;
    $fell(pu_reg[0]) |-> $past(rel[0]) || !$past(en[0]);
  endproperty
  a_release: assert property (p_release) else $error("pick-up released early");
  property p_block;
    (st_reg[0] == thd_alarm_pkg::ST_NORMAL && pu_reg[0] && i_block) |=> o_blocked && !o_start[0];
  endproperty
  a_block: assert property (p_block) else $error("start while blocked");
  property p_alarm_clr;
    (o_alarm[1] && !pu_reg[1]) |=> !o_alarm[1] && !o_start[1];
  endproperty
  a_alarm_clr: assert property (p_alarm_clr) else $error("alarm kept after release");

  c_ph_alarm: cover property ($rose(o_alarm[0]));
  c_blocked:  cover property ($rose(o_blocked));
  c_wrap:     cover property (rec_we && ptr_reg == 4'(REC_DEPTH - 1));
  c_evt_off:  cover property (o_evt_valid && o_evt_code[0]);
endmodule : thd_alarm_timer_event_log
`default_nettype wire

// ### include/thd_alarm_map.svh
// register map, field positions, reset values and timing figures
`ifndef THD_ALARM_MAP_SVH
`define THD_ALARM_MAP_SVH
`define THD_OFS_CTRL      8'h00
`define THD_OFS_PICK_PH   8'h04
`define THD_OFS_DLY_PH    8'h10
`define THD_OFS_EVT_MASK  8'h1c
`define THD_OFS_STATUS    8'h20
`define THD_OFS_CNT_START 8'h24
`define THD_OFS_CNT_ALARM 8'h28
`define THD_OFS_CNT_BLOCK 8'h2c
`define THD_OFS_REC_SEL   8'h30
`define THD_OFS_REC_TS_LO 8'h34
`define THD_OFS_REC_TS_HI 8'h38
`define THD_OFS_REC_THD_A 8'h3c
`define THD_OFS_REC_THD_B 8'h40
`define THD_WORD          8'h04
`define THD_CTRL_MODE     0
`define THD_CTRL_EN_LSB   1
`define THD_CTRL_CLR      4
`define THD_EN_RST        3'h7
`define THD_PICK_RST      14'h03e8
`define THD_DLY_RST       19'h007d0
`define THD_MASK_RST      14'h3fff
`define THD_RST_PCT       10'h061
`define THD_FULL_PCT      10'h064
`define THD_STEP_NS       5000000
`define THD_CLK_NS        4
`define THD_REC_DEPTH     12
`endif

// ### include/thd_alarm_pkg.sv
// types shared by the harmonic alarm block
package thd_alarm_pkg;
  typedef enum logic [1:0] {ST_NORMAL, ST_START, ST_ALARM, ST_BLOCKED} chan_state_e;
  typedef logic [13:0] pick_t;
  typedef logic [18:0] dly_t;
  typedef logic [15:0] cnt_t;
endpackage : thd_alarm_pkg

// ### logic/thd_record_mem.sv
// small record store with registered read data
`timescale 1ns/1ps
`default_nettype none
module thd_record_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 12,
  parameter int AW    = 4
) (
  input  wire logic             i_clock,  // core clock
  input  wire logic             i_we,     // write strobe
  input  wire logic [AW-1:0]    i_waddr,  // write slot
  input  wire logic [WIDTH-1:0] i_wdata,  // write word
  input  wire logic [AW-1:0]    i_raddr,  // read slot
  output logic      [WIDTH-1:0] o_rdata   // registered read word
);
  logic [WIDTH-1:0] mem [DEPTH];

  // write port
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // read port, registered
  always_ff @(posedge i_clock) begin
    o_rdata <= mem[i_raddr];
  end
endmodule : thd_record_mem
`default_nettype wire

// ### dv/thd_meas_stage.sv
// measurement stage model: distortion ratios and a millisecond time base
`timescale 1ns/1ps
`default_nettype none
module thd_meas_stage #(
  parameter int TS_DIV = 16
) (
  input  wire logic        i_clock,      // core clock
  input  wire logic        i_nrst,       // sync reset, active low
  input  wire logic [79:0] i_amp_set,    // wanted amplitude ratios
  input  wire logic [79:0] i_pow_set,    // wanted power ratios
  output logic      [79:0] o_thd_amp,    // amplitude ratios to the block
  output logic      [79:0] o_thd_pow,    // power ratios to the block
  output logic      [47:0] o_timestamp   // time in ms
);
  int div;

  // new ratios every cycle, time advances once per TS_DIV cycles
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      div         <= 0;
      o_timestamp <= 48'h0;
      o_thd_amp   <= 80'h0;
      o_thd_pow   <= 80'h0;
    end else begin
      o_thd_amp <= i_amp_set;
      o_thd_pow <= i_pow_set;
      div       <= (div == TS_DIV - 1) ? 0 : div + 1;
      if (div == TS_DIV - 1) begin
        o_timestamp <= o_timestamp + 48'h1;
      end
    end
  end
endmodule : thd_meas_stage
`default_nettype wire

// ### dv/thd_alarm_timer_event_log_tb.sv
// bench for the harmonic alarm timer and event log
`timescale 1ns/1ps
`default_nettype none
`include "thd_alarm_map.svh"
`define CMP(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s expected %h seen %h", n, e, g); end end
`define WAIT_FOR(c) begin @(negedge i_clock); for (int k = 0; k < 400 && !(c); k++) @(negedge i_clock); if (!(c)) begin fail_count++; $display("unexpected wait condition expected 1 seen 0"); end end
module thd_alarm_timer_event_log_tb;
  localparam int TICK = 4;
  logic        i_clock, nrst, psel, pen, pwr, blk, pready, pslverr, err, evt_v, blocked;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [79:0] amp_set, pow_set, amp, pow;
  logic [47:0] ts, evt_t;
  logic [2:0]  grp, start, alarm;
  logic [3:0]  evt_c, last_rise;
  int          fail_count, samples_checked, rises, s4, s5;
  int          seen[16];

  thd_meas_stage #(.TS_DIV(16)) i_meas (.i_clock(i_clock), .i_nrst(nrst), .i_amp_set(amp_set),
    .i_pow_set(pow_set), .o_thd_amp(amp), .o_thd_pow(pow), .o_timestamp(ts));
  thd_alarm_timer_event_log #(.TICK_CYCLES(TICK)) i_dut (.i_clock(i_clock), .i_nrst(nrst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_thd_amp(amp), .i_thd_pow(pow), .i_block(blk),
    .i_set_group(grp), .i_timestamp(ts), .o_start(start), .o_alarm(alarm), .o_blocked(blocked),
    .o_evt_valid(evt_v), .o_evt_code(evt_c), .o_evt_time(evt_t));

  // clock
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clock);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clock);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    `CMP("pready", 1'b1, pready)
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CMP(nm, e, rd)
  endtask : chk_rd

  // set the ratio of one input, 0..2 phases, 3..4 residuals
  task automatic set_thd(input logic p, input int ch, input logic [15:0] v);
    @(posedge i_clock);
    if (p) pow_set[ch*16 +: 16] <= v;
    else amp_set[ch*16 +: 16] <= v;
  endtask : set_thd

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // tally events and check their time stamps
  always @(negedge i_clock) begin
    if (evt_v === 1'b1) begin
      seen[evt_c]++;
      `CMP("event time", 1'b1, (ts - evt_t) <= 48'h2)
      if (evt_c[0] === 1'b0) begin
        rises++;
        last_rise = evt_c;
      end
    end
  end

  // watchdog
  initial begin
    repeat (40000) @(posedge i_clock);
    fail_count++;
    give_verdict();
  end

  initial begin
    {nrst, psel, pen, pwr, blk, paddr, pwdata, amp_set, pow_set} = '0;
    grp = 3'h5;
    repeat (12) @(posedge i_clock);
    nrst <= 1'b1;
    `CMP("start after reset", 3'h0, start)
    chk_rd(`THD_OFS_CTRL, 32'h0000000e, "control");
    chk_rd(`THD_OFS_EVT_MASK, 32'h00003fff, "event mask");
    for (int c = 0; c < 3; c++) begin
      chk_rd(`THD_OFS_PICK_PH + 8'(4*c), 32'h000003e8, "pickup");
      chk_rd(`THD_OFS_DLY_PH + 8'(4*c), 32'h000007d0, "delay default");
    end
    chk_rd(8'h44, 32'h0, "unmapped data");
    `CMP("unmapped error", 1'b1, err)
    apb(1'b1, `THD_OFS_DLY_PH, 32'h3);
    apb(1'b1, `THD_OFS_DLY_PH + `THD_WORD, 32'h0);
    apb(1'b1, `THD_OFS_DLY_PH + 8'h08, 32'ha);
    chk_rd(`THD_OFS_DLY_PH, 32'h3, "phase delay");
    // phase channel: pick-up, timing, hysteresis
    set_thd(1'b0, 1, 16'h03e9);
    `WAIT_FOR(start[0] === 1'b1)
    `CMP("phase start", 1'b1, start[0])
    repeat (3*TICK - 1) @(negedge i_clock);
    `CMP("phase alarm early", 1'b0, alarm[0])
    `WAIT_FOR(alarm[0] === 1'b1)
    `CMP("phase alarm", 1'b1, alarm[0])
    set_thd(1'b0, 1, 16'h03cb);
    repeat (8) @(negedge i_clock);
    `CMP("start in band", 1'b1, start[0])
    set_thd(1'b0, 1, 16'h03c9);
    `WAIT_FOR(start[0] === 1'b0)
    `CMP("start released", 1'b0, start[0])
    `CMP("alarm released", 1'b0, alarm[0])
    // residual channels time on their own delays
    set_thd(1'b0, 3, 16'h07d0);
    set_thd(1'b0, 4, 16'h07d0);
    `WAIT_FOR(alarm[1] === 1'b1)
    `CMP("residual one alarm", 1'b1, alarm[1])
    `CMP("residual two waits", 1'b0, alarm[2])
    `WAIT_FOR(alarm[2] === 1'b1)
    `CMP("residual two alarm", 1'b1, alarm[2])
    set_thd(1'b0, 3, 16'h0);
    set_thd(1'b0, 4, 16'h0);
    `WAIT_FOR(start[2:1] === 2'b00)
    // ratio selection
    apb(1'b1, `THD_OFS_CTRL, 32'hf);
    set_thd(1'b1, 4, 16'h0bb8);
    `WAIT_FOR(start[2] === 1'b1)
    `CMP("power ratio start", 1'b1, start[2])
    apb(1'b1, `THD_OFS_CTRL, 32'he);
    `WAIT_FOR(start[2] === 1'b0)
    `CMP("amplitude ratio", 1'b0, start[2])
    set_thd(1'b1, 4, 16'h0);
    // blocking at pick-up
    @(posedge i_clock);
    blk <= 1'b1;
    set_thd(1'b0, 0, 16'h07d0);
    `WAIT_FOR(blocked === 1'b1)
    `CMP("blocked", 1'b1, blocked)
    repeat (30) @(negedge i_clock);
    `CMP("blocked no timing", 2'b00, {start[0], alarm[0]})
    set_thd(1'b0, 0, 16'h01f4);
    `WAIT_FOR(blocked === 1'b0)
    @(posedge i_clock);
    blk <= 1'b0;
    // repeated rises to wrap the record store
    for (int i = 0; i < 6; i++) begin
      set_thd(1'b0, 3, 16'h07d0);
      `WAIT_FOR(alarm[1] === 1'b1)
      set_thd(1'b0, 3, 16'h0);
      `WAIT_FOR(start[1] === 1'b0)
    end
    repeat (20) @(negedge i_clock);
    for (int c = 0; c < 14; c++) `CMP("event code seen", 1'b1, seen[c] > 0)
    // scenario so far: ten start rises, nine alarm rises, one blocked rise
    `CMP("rise events", 20, rises)
    `CMP("last rise event", 4'h8, last_rise)
    chk_rd(`THD_OFS_CNT_START, 32'h0000000a, "start count");
    chk_rd(`THD_OFS_CNT_ALARM, 32'h00000009, "alarm count");
    chk_rd(`THD_OFS_CNT_BLOCK, 32'h00000001, "blocked count");
    chk_rd(`THD_OFS_STATUS, 32'h0000c800, "records");
    apb(1'b1, `THD_OFS_REC_SEL, 32'h7);
    apb(1'b0, `THD_OFS_REC_TS_HI, 32'h0);
    `CMP("record group", 3'h5, rd[26:24])
    `CMP("record event", 4'h8, rd[23:20])
    apb(1'b0, `THD_OFS_REC_THD_A, 32'h0);
    `CMP("record phase one", 16'h01f4, rd[15:0])
    `CMP("record phase two", 16'h03c9, rd[31:16])
    apb(1'b0, `THD_OFS_REC_TS_LO, 32'h0);
    `CMP("record time", 1'b1, (ts[31:0] - rd) <= 32'h00000010)
    apb(1'b1, `THD_OFS_CTRL, 32'h1e);
    chk_rd(`THD_OFS_CNT_START, 32'h0, "start count cleared");
    // a masked falling event never appears
    apb(1'b1, `THD_OFS_EVT_MASK, 32'h3fdf);
    s4 = seen[4];
    s5 = seen[5];
    set_thd(1'b0, 4, 16'h07d0);
    `WAIT_FOR(start[2] === 1'b1)
    set_thd(1'b0, 4, 16'h0);
    `WAIT_FOR(start[2] === 1'b0)
    repeat (20) @(negedge i_clock);
    `CMP("unmasked rise", s4 + 1, seen[4])
    `CMP("masked fall", s5, seen[5])
    give_verdict();
  end
endmodule : thd_alarm_timer_event_log_tb
`default_nettype wire
